// file: stepper_pkg.sv
// Constants shared by the microstepping indexer
package stepper_pkg;
  // Clock and time base
  localparam int CLK_HZ = 125_000_000;
  localparam int FREQ_UNIT_HZ = 10;
  localparam int OSC_WRAP_INT = CLK_HZ / FREQ_UNIT_HZ;
  localparam logic [23:0] OSC_WRAP = 24'(OSC_WRAP_INT);
  localparam int IDLE_TIME_MS = 1000;
  localparam int IDLE_CYCLES_DEF = (CLK_HZ / 1000) * IDLE_TIME_MS;
  localparam int RAMP_TICK_US = 100;
  localparam int RAMP_TICK_CYCLES_DEF = (CLK_HZ / 1_000_000) * RAMP_TICK_US;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_RAMP = 8'h04;
  localparam logic [7:0] REG_DROP = 8'h08;
  localparam logic [7:0] REG_PHASE_CUR = 8'h0C;
  localparam logic [7:0] REG_START_FREQ = 8'h10;
  localparam logic [7:0] REG_PRESET_DIR = 8'h14;
  localparam logic [7:0] REG_FREQ_BASE = 8'h18;
  localparam logic [7:0] REG_DIST_BASE = 8'h28;
  localparam logic [7:0] REG_STATUS = 8'h50;
  localparam logic [7:0] REG_REMAIN = 8'h54;
  localparam logic [7:0] REG_STEPCNT = 8'h58;
  localparam logic [7:0] REG_POSITION = 8'h5C;
  localparam logic [7:0] FREQ_STRIDE = 8'h04;
  localparam logic [7:0] DIST_STRIDE = 8'h08;
  localparam logic [7:0] DIST_HI_OFS = 8'h04;

  // Control register fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_PRESET_EN_BIT = 3;

  // Reset values
  localparam logic [2:0] MODE_RST = 3'h3;
  localparam logic [5:0] RAMP_RST = 6'h0A;
  localparam logic [2:0] DROP_RST = 3'h1;
  localparam logic [5:0] PHASE_CUR_RST = 6'h0A;
  localparam logic [9:0] FREQ_RST = 10'h00A;
  localparam logic [3:0] PRESET_DIR_RST = 4'h0;
  localparam logic [9:0] DIST_RST = 10'h000;

  // Current drop settings
  localparam logic [2:0] DROP_HALF = 3'h2;
  localparam logic [2:0] DROP_QUARTER = 3'h3;
  localparam logic [2:0] DROP_OFF = 3'h4;

  // Distance scaling and microstep size
  localparam logic [9:0] DIST_KILO = 10'd1000;
  localparam logic [6:0] MICRO_PER_FULL = 7'h40;
  localparam int NUM_PRESETS = 4;

  typedef enum logic [1:0] {
    RUN_IDLE = 2'b00,
    RUN_ACCEL = 2'b01,
    RUN_CRUISE = 2'b10,
    RUN_DECEL = 2'b11
  } run_state_t;
endpackage

// file: rise_detect.sv
// Rising edge detector for a synchronous input level
module rise_detect (
  input wire logic clk,
  input wire logic resetn,
  input wire logic level,
  output logic rise
);
  logic prev;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prev <= 1'b0;
    end else begin
      prev <= level;
    end
  end

  assign rise = level & ~prev;
endmodule

// file: stepper_indexer.sv
// Indexer, oscillator and settings of a microstepping stepper driver
// Notes on behaviour
// - Each rising step input edge outside a preset run moves one step of the chosen resolution.
// - Without presets, the direction input level sets external step direction.
// - With presets, direction input stops the run and clears the sequence.
// - Stop and reset act only on the rising edge of the direction input.
// - Disable turns the power stage off and blocks all motion while held.
// - Disable keeps the sequence state and counters; a direction stop still clears the run.
// - Each preset input starts its run with its own direction, rate, distance.
// - Zero distance runs continuously while the input stays high or until stop.
// - Mode 0..6 selects full down to 1/64 step; default is 1/8.
// - One ramp time, 0.1 s units, default 10, for speeding up and down.
// - One second after stepping stops, current drops per setting 1..4.
// - Running phase current code 1..60 in 0.1 A, default 10.
// - Each preset has a direction bit, 0 forward, 1 reverse, default 0.
// - Each preset rate code is 5..1000 in 10 Hz units, default 10.
// - Distance is low part plus thousands part, counted in microsteps.
// - Preset runs begin at the start rate then ramp toward the target.
// - A readable down counter of remaining steps decrements to zero.
// - Step counter clears at each new run; last started preset is kept.
module stepper_indexer
  import stepper_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_CYCLES_DEF,
  parameter int RAMP_TICK_CYCLES = RAMP_TICK_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic step_in,
  input wire logic dir_in,
  input wire logic disable_in,
  input wire logic [3:0] preset_in,
  output logic stage_on,
  output logic step_out,
  output logic dir_out,
  output logic [15:0] position,
  output logic [5:0] current_code
);
  import stepper_pkg::*;

  localparam logic [26:0] IDLE_LIMIT = 27'(IDLE_CYCLES);
  localparam logic [15:0] TICK_LIMIT = 16'(RAMP_TICK_CYCLES);

  // Settings
  logic [2:0] mode;
  logic preset_en;
  logic [5:0] ramp, phase_cur;
  logic [2:0] drop;
  logic [9:0] start_freq;
  logic [3:0] preset_dir;
  logic [9:0] preset_freq [NUM_PRESETS];
  logic [9:0] dist_lo [NUM_PRESETS], dist_hi [NUM_PRESETS];
  // Run state
  run_state_t state;
  logic [1:0] active, last_preset;
  logic last_valid, run_dir, continuous, rested;
  logic [9:0] freq_cur, target;
  logic [23:0] acc;
  logic [20:0] remain, accel_steps;
  logic [31:0] step_count;
  logic [15:0] tick_cnt;
  logic [5:0] ramp_sub;
  logic [26:0] idle_cnt;

  // One edge detector per pin: step, direction, then the presets
  logic step_rise, dir_rise;
  logic [3:0] preset_rise;
  logic [NUM_PRESETS + 1:0] pin_level, pin_rise;
  assign pin_level = {preset_in, dir_in, step_in};
  assign {preset_rise, dir_rise, step_rise} = pin_rise;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRESETS + 2; gi++) begin : g_pin_edge
      rise_detect u_edge (
        .clk(clk),
        .resetn(resetn),
        .level(pin_level[gi]),
        .rise(pin_rise[gi])
      );
    end
  endgenerate

  // Lowest asserted preset wins
  logic [1:0] pick;
  always_comb begin
    pick = 2'h0;
    for (int i = NUM_PRESETS - 1; i >= 0; i--) begin
      if (preset_in[i]) begin
        pick = 2'(i);
      end
    end
  end

  logic running, stop_req, start_req;
  assign running = (state != RUN_IDLE);
  assign stop_req = preset_en && dir_rise;
  assign start_req = preset_en && !running && !disable_in && !stop_req
                     && (|preset_rise);
  // Distance: low part plus thousands, widened before the product
  logic [20:0] pick_dist;
  assign pick_dist = 21'(dist_hi[pick]) * 21'(DIST_KILO)
                     + 21'(dist_lo[pick]);
  // Oscillator step tick
  logic [24:0] acc_sum;
  logic osc_step;
  assign acc_sum = {1'b0, acc} + {15'h0000, freq_cur};
  assign osc_step = running && !disable_in && (acc_sum >= {1'b0, OSC_WRAP});
  // Ramp tick: one rate code per ramp setting plus one, times 100 us
  logic ramp_step;
  assign ramp_step = running && !disable_in && (tick_cnt == TICK_LIMIT - 1'b1)
                     && (ramp_sub >= ramp);
  logic ext_step, any_step;
  assign ext_step = step_rise && !disable_in && !running;
  assign any_step = ext_step || osc_step;
  logic [6:0] step_inc;
  assign step_inc = MICRO_PER_FULL >> mode;
  logic want_decel;
  assign want_decel = continuous ? !preset_in[active]
                                 : (remain <= accel_steps);

  // Register writes
  logic [7:0] freq_addr [NUM_PRESETS];
  logic [7:0] dlo_addr [NUM_PRESETS];
  always_comb begin
    for (int i = 0; i < NUM_PRESETS; i++) begin
      freq_addr[i] = REG_FREQ_BASE + 8'(i) * FREQ_STRIDE;
      dlo_addr[i] = REG_DIST_BASE + 8'(i) * DIST_STRIDE;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode <= MODE_RST;
      preset_en <= 1'b0;
      ramp <= RAMP_RST;
      drop <= DROP_RST;
      phase_cur <= PHASE_CUR_RST;
      start_freq <= FREQ_RST;
      preset_dir <= PRESET_DIR_RST;
      for (int i = 0; i < NUM_PRESETS; i++) begin
        preset_freq[i] <= FREQ_RST;
        dist_lo[i] <= DIST_RST;
        dist_hi[i] <= DIST_RST;
      end
    end else if (wr) begin
      unique case (addr)
        REG_CTRL: begin
          mode <= wdata[CTRL_MODE_LSB +: 3];
          preset_en <= wdata[CTRL_PRESET_EN_BIT];
        end
        REG_RAMP: ramp <= wdata[5:0];
        REG_DROP: drop <= wdata[2:0];
        REG_PHASE_CUR: phase_cur <= wdata[5:0];
        REG_START_FREQ: start_freq <= wdata[9:0];
        REG_PRESET_DIR: preset_dir <= wdata[3:0];
        default: begin
          for (int i = 0; i < NUM_PRESETS; i++) begin
            if (addr == freq_addr[i]) begin
              preset_freq[i] <= wdata[9:0];
            end
            if (addr == dlo_addr[i]) begin
              dist_lo[i] <= wdata[9:0];
            end
            if (addr == dlo_addr[i] + DIST_HI_OFS) begin
              dist_hi[i] <= wdata[9:0];
            end
          end
        end
      endcase
    end
  end

  // Run sequencer; frozen while disabled, but a direction stop still clears it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state <= RUN_IDLE;
      active <= 2'h0;
      run_dir <= 1'b0;
      continuous <= 1'b0;
      freq_cur <= FREQ_RST;
      target <= FREQ_RST;
      remain <= 21'h000000;
      accel_steps <= 21'h000000;
    end else if (stop_req) begin
      state <= RUN_IDLE;
      remain <= 21'h000000;
      accel_steps <= 21'h000000;
    end else if (start_req) begin
      state <= RUN_ACCEL;
      active <= pick;
      run_dir <= preset_dir[pick];
      continuous <= (pick_dist == 21'h000000);
      remain <= pick_dist;
      accel_steps <= 21'h000000;
      freq_cur <= start_freq;
      target <= (preset_freq[pick] > start_freq) ? preset_freq[pick]
                                                  : start_freq;
    end else if (running && !disable_in) begin
      if (osc_step && !continuous) begin
        remain <= remain - 1'b1;
      end
      if (osc_step && state == RUN_ACCEL) begin
        accel_steps <= accel_steps + 1'b1;
      end
      unique case (state)
        RUN_ACCEL: begin
          if (want_decel) begin
            state <= RUN_DECEL;
          end else if (freq_cur >= target) begin
            state <= RUN_CRUISE;
          end else if (ramp_step) begin
            freq_cur <= freq_cur + 1'b1;
          end
        end
        RUN_CRUISE: begin
          if (want_decel) begin
            state <= RUN_DECEL;
          end
        end
        RUN_DECEL: begin
          if (continuous && freq_cur <= start_freq) begin
            state <= RUN_IDLE;
          end else if (ramp_step && freq_cur > start_freq) begin
            freq_cur <= freq_cur - 1'b1;
          end
        end
        RUN_IDLE: begin
        end
      endcase
      // Last planned step ends the run
      if (!continuous && (remain == 21'h000000 ||
                          (osc_step && remain == 21'h000001))) begin
        state <= RUN_IDLE;
      end
    end
  end

  // Oscillator phase accumulator and ramp divider
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      acc <= 24'h000000;
      tick_cnt <= 16'h0000;
      ramp_sub <= 6'h00;
    end else if (!running || start_req) begin
      acc <= 24'h000000;
      tick_cnt <= 16'h0000;
      ramp_sub <= 6'h00;
    end else if (!disable_in) begin
      acc <= osc_step ? 24'(acc_sum - {1'b0, OSC_WRAP}) : acc_sum[23:0];
      if (tick_cnt == TICK_LIMIT - 1'b1) begin
        tick_cnt <= 16'h0000;
        ramp_sub <= ramp_step ? 6'h00 : ramp_sub + 1'b1;
      end else begin
        tick_cnt <= tick_cnt + 1'b1;
      end
    end
  end
  // Monitor counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_count <= 32'h00000000;
      last_preset <= 2'h0;
      last_valid <= 1'b0;
    end else if (start_req) begin
      step_count <= 32'h00000000;
      last_preset <= pick;
      last_valid <= 1'b1;
    end else if (osc_step) begin
      step_count <= step_count + 1'b1;
    end
  end

  // Motor position in 1/64 step units and step strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      position <= 16'h0000;
      step_out <= 1'b0;
      dir_out <= 1'b0;
    end else begin
      step_out <= any_step;
      if (any_step) begin
        // Direction pin level only matters without presets
        dir_out <= ext_step ? (preset_en ? run_dir : dir_in) : run_dir;
        if ((ext_step && !preset_en) ? dir_in : run_dir) begin
          position <= position - 16'(step_inc);
        end else begin
          position <= position + 16'(step_inc);
        end
      end
    end
  end
  // Rest timer and current level
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      idle_cnt <= 27'h0000000;
      rested <= 1'b0;
    end else if (any_step) begin
      idle_cnt <= 27'h0000000;
      rested <= 1'b0;
    end else if (idle_cnt >= IDLE_LIMIT - 1'b1) begin
      rested <= 1'b1;
    end else begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_on <= 1'b0;
      current_code <= 6'h00;
    end else begin
      stage_on <= !disable_in;
      if (disable_in || (rested && drop == DROP_OFF)) begin
        current_code <= 6'h00;
      end else if (rested && drop == DROP_HALF) begin
        current_code <= phase_cur >> 1;
      end else if (rested && drop == DROP_QUARTER) begin
        current_code <= phase_cur >> 2;
      end else begin
        current_code <= phase_cur;
      end
    end
  end

  // Register reads, data valid the cycle after the strobe
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h00000000;
    unique case (addr)
      REG_CTRL: next_rdata = {28'h0, preset_en, mode};
      REG_RAMP: next_rdata = {26'h0, ramp};
      REG_DROP: next_rdata = {29'h0, drop};
      REG_PHASE_CUR: next_rdata = {26'h0, phase_cur};
      REG_START_FREQ: next_rdata = {22'h0, start_freq};
      REG_PRESET_DIR: next_rdata = {28'h0, preset_dir};
      REG_STATUS: next_rdata = {24'h0, rested, run_dir, last_valid,
                                last_preset, disable_in, state};
      REG_REMAIN: next_rdata = {11'h0, remain};
      REG_STEPCNT: next_rdata = step_count;
      REG_POSITION: next_rdata = {16'h0, position};
      default: begin
        for (int i = 0; i < NUM_PRESETS; i++) begin
          if (addr == freq_addr[i]) begin
            next_rdata = {22'h0, preset_freq[i]};
          end
          if (addr == dlo_addr[i]) begin
            next_rdata = {22'h0, dist_lo[i]};
          end
          if (addr == dlo_addr[i] + DIST_HI_OFS) begin
            next_rdata = {22'h0, dist_hi[i]};
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 32'h00000000;
    end else begin
      rdata <= rd ? next_rdata : 32'h00000000;
    end
  end
endmodule

// file: stepper_indexer_assertions.sv
// Port-level checks of the stepper indexer
module stepper_indexer_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic disable_in,
  input wire logic stage_on,
  input wire logic step_out,
  input wire logic dir_out,
  input wire logic [15:0] position,
  input wire logic [5:0] current_code
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  AST_STAGE_TRACKS: assert property (
    1 |=> stage_on == !$past(disable_in))
    else $error("stage enable does not follow disable");
  AST_DIS_NO_STEP: assert property (
    disable_in |=> !step_out)
    else $error("step while disabled");
  AST_DIS_NO_CUR: assert property (
    disable_in |=> current_code == 6'h00 && !stage_on)
    else $error("current while disabled");
  AST_STEP_POWERED: assert property (
    step_out |-> stage_on)
    else $error("step with stage off");
  // Mode 0..6 moves 64 down to 1 units; sign set by the step direction
  AST_STEP_MOVES: assert property (
    step_out |-> 16'(dir_out ? $past(position) - position
      : position - $past(position)) inside {[16'h0001:16'h0040]})
    else $error("step moved wrong amount");
  AST_POS_HOLD: assert property (
    !step_out |-> $stable(position))
    else $error("position moved without step");
  AST_PULSE_ONE: assert property (
    step_out |=> !step_out)
    else $error("step pulse longer than one cycle");
  AST_RD_IDLE: assert property (
    !$past(rd) |-> rdata == 32'h0)
    else $error("read data outside answer cycle");

  cover property (step_out && dir_out);
  cover property (step_out && !dir_out);
  cover property ($fell(stage_on));
  cover property (stage_on && current_code == 6'h00);
endmodule

bind stepper_indexer stepper_indexer_assertions chk (.clk(clk),
  .resetn(resetn), .rd(rd), .rdata(rdata), .disable_in(disable_in),
  .stage_on(stage_on), .step_out(step_out), .dir_out(dir_out),
  .position(position), .current_code(current_code));

// file: step_source.sv
// Controller-side step pulse source with a settable low gap
module step_source (
  input wire logic clk,
  input wire logic resetn,
  input wire logic go,
  input wire logic [3:0] gap,
  output logic step_in,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt;
  assign busy = step_in || cnt != 4'h0;
  // High one cycle, then low at least gap cycles (one when gap is 0) so edges never merge
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      step_in <= 1'b0;
      cnt <= 4'h0;
    end else if (go && !busy) begin
      step_in <= 1'b1;
      cnt <= gap;
    end else begin
      step_in <= 1'b0;
      if (cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end
    end
  end
endmodule

// file: stepper_indexer_tb.sv
// Self-checking bench for the stepper indexer
module stepper_indexer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import stepper_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic dir_in = 1'b0;
  logic disable_in = 1'b0;
  logic go = 1'b0;
  logic [3:0] preset_in = 4'h0;
  logic [3:0] gap = 4'h1;
  logic [31:0] rdata, d;
  logic step_in, busy, stage_on, step_out, dir_out;
  logic [15:0] position;
  logic [5:0] current_code;
  logic [31:0] seed = 32'h68E4F450;
  logic [15:0] exp_pos = 16'h0;
  // Each note holds the step direction above the expected position
  logic [16:0] exp_q[$];
  logic [16:0] exp_step;
  int miscompares = 0;
  int checks_done = 0;
  logic [39:0] rst_tab[10] = '{{REG_CTRL, 32'h3}, {REG_RAMP, 32'hA},
    {REG_DROP, 32'h1}, {REG_PHASE_CUR, 32'hA}, {REG_START_FREQ, 32'hA},
    {REG_PRESET_DIR, 32'h0}, {REG_FREQ_BASE, 32'hA}, {8'h24, 32'hA},
    {8'h44, 32'h0}, {8'h60, 32'h0}};
  logic [5:0] drop_exp[4] = '{6'h14, 6'h0A, 6'h05, 6'h00};

  always #4 clk = ~clk;

  stepper_indexer #(.IDLE_CYCLES(50), .RAMP_TICK_CYCLES(4)) uut (
    .clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .step_in(step_in), .dir_in(dir_in),
    .disable_in(disable_in), .preset_in(preset_in), .stage_on(stage_on),
    .step_out(step_out), .dir_out(dir_out), .position(position),
    .current_code(current_code));
  step_source src (.clk(clk), .resetn(resetn), .go(go), .gap(gap),
    .step_in(step_in), .busy(busy));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    v = rdata;
  endtask

  task automatic expect_step(input logic rev, input logic [6:0] sz);
    exp_pos = rev ? exp_pos - 16'(sz) : exp_pos + 16'(sz);
    exp_q.push_back({rev, exp_pos});
  endtask

  // Blocked pulses push nothing, so any step they cause is flagged
  task automatic pulse(input logic moves, input logic [6:0] sz);
    if (moves) begin
      expect_step(dir_in, sz);
    end
    @(posedge clk);
    seed = xs(seed);
    gap <= 4'h1 + 4'(seed[2:0]);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (20) begin
      @(posedge clk);
      if (!busy) break;
    end
  endtask

  task automatic wait_q(input int n);
    repeat (30000) begin
      @(posedge clk);
      if (exp_q.size() <= n) break;
    end
  endtask

  always @(posedge clk) begin
    if (resetn && step_out === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("unexpected step", 32'h1, 32'h0);
      end else begin
        exp_step = exp_q.pop_front();
        check("position", 32'(position), 32'(exp_step[15:0]));
        check("direction", 32'(dir_out), 32'(exp_step[16]));
      end
    end
  end

  initial begin
    repeat (90000) @(posedge clk);
    miscompares++;
    wrap_up();
  end

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    foreach (rst_tab[i]) begin
      rreg(rst_tab[i][39:32], d);
      check("reset value", d, rst_tab[i][31:0]);
    end
    wreg(REG_PHASE_CUR, 32'h14);
    for (int m = 0; m < 7; m++) begin
      wreg(REG_CTRL, 32'(m));
      seed = xs(seed);
      dir_in <= seed[0];
      @(posedge clk);
      pulse(1'b1, MICRO_PER_FULL >> m);
      pulse(1'b1, MICRO_PER_FULL >> m);
    end
    foreach (drop_exp[i]) begin
      wreg(REG_DROP, 32'(i + 1));
      pulse(1'b1, 7'h01);
      // Current level follows the rest flag one cycle later
      repeat (2) @(posedge clk);
      check("run current", 32'(current_code), 32'h14);
      repeat (60) @(posedge clk);
      check("rest current", 32'(current_code), 32'(drop_exp[i]));
    end
    disable_in <= 1'b1;
    pulse(1'b0, 7'h01);
    check("stage off", 32'(stage_on), 32'h0);
    disable_in <= 1'b0;
    dir_in <= 1'b0;
    repeat (2) @(posedge clk);
    check("stage on", 32'(stage_on), 32'h1);
    // Start rate equals target, so no ramp stretches the run
    wreg(REG_START_FREQ, 32'h3E8);
    wreg(REG_PRESET_DIR, 32'h2);
    wreg(REG_FREQ_BASE, 32'h3E8);
    wreg(REG_FREQ_BASE + FREQ_STRIDE, 32'h3E8);
    wreg(REG_DIST_BASE + DIST_STRIDE, 32'h3);
    wreg(REG_CTRL, 32'hE);
    repeat (3) expect_step(1'b1, 7'h01);
    preset_in <= 4'b0110;
    wait_q(2);
    rreg(REG_REMAIN, d);
    check("remain", d, 32'h2);
    wait_q(0);
    repeat (20) @(posedge clk);
    rreg(REG_REMAIN, d);
    check("remain end", d, 32'h0);
    rreg(REG_STEPCNT, d);
    check("step count", d, 32'h3);
    rreg(REG_STATUS, d);
    check("last preset", 32'(d[5:3]), 32'h5);
    check("idle state", 32'(d[1:0]), 32'h0);
    preset_in <= 4'h0;
    dir_in <= 1'b1;
    repeat (2) @(posedge clk);
    expect_step(1'b0, 7'h01);
    preset_in <= 4'b0001;
    wait_q(0);
    disable_in <= 1'b1;
    repeat (13000) @(posedge clk);
    rreg(REG_STATUS, d);
    check("run kept", 32'(d[1:0] != 2'b00), 32'h1);
    dir_in <= 1'b0;
    @(posedge clk);
    dir_in <= 1'b1;
    repeat (2) @(posedge clk);
    disable_in <= 1'b0;
    rreg(REG_STATUS, d);
    check("run stopped", 32'(d[1:0]), 32'h0);
    repeat (13000) @(posedge clk);
    wrap_up();
  end
endmodule
